// file: rtl/pdc_pkg.sv
// constants, field layout and helpers for the device control register block
// How it works
// R01: bit 15 is reserved, always reads zero, writes to it are dropped
// R02: bits 14:12 set maximum read request size, 128B to 4096B, 110/111 reserved
// R03: fetch size for reads combines read request size with cache line size
// R04: bits 7:5 set maximum payload, same 128B to 4096B coding, 110/111 reserved
// R05: bit 11 no snoop enable reads zero and ignores writes
// R06: bit 10 aux power enable is hardwired to read zero
// R07: bit 9 phantom function enable is hardwired to read zero
// R08: bit 8 extended tag enable is hardwired to read zero
// R09: bit 4 relaxed ordering enable is hardwired to read zero
// R10: bit 3 set sends nonfatal message on unsupported request at upstream port
// R11: bit 2 set sends fatal message on a fatal error event
// R12: bit 1 set sends nonfatal message on a nonfatal error event
// R13: bit 0 set sends correctable message on a correctable error event
// R14: status flags log every error whatever the reporting enables say
// R15: reset loads 512B read request size and zero in every other field
`default_nettype none
package pdc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] PCIE_DEVICE_CONTROL_OFS = 12'h098;
	localparam logic [11:0] PCIE_DEVICE_STATUS_OFS  = 12'h09A;
	localparam logic [15:0] PCIE_DEVICE_CONTROL_RST = 16'h2000;
	localparam logic [15:0] PCIE_DEVICE_STATUS_RST  = 16'h0000;
	localparam logic [15:0] CTRL_WR_MASK            = 16'h70EF;
	localparam logic [15:0] STAT_W1C_MASK           = 16'h000F;
	localparam logic [15:0] RD_UNMAPPED             = 16'h0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int RRS_LSB       = 12;
	localparam int MPL_LSB       = 5;
	localparam int UR_REP_BIT    = 3;
	localparam int FATAL_REP_BIT = 2;
	localparam int NF_REP_BIT    = 1;
	localparam int CORR_REP_BIT  = 0;
	localparam int ST_PEND_BIT   = 5;
	localparam int ST_AUX_BIT    = 4;
	localparam int SIZE_W        = 13;
	localparam int CLS_W_DEF     = 8;
	localparam int CLS_W_MAX     = 8;

	// ----------------------------------------------------------------
	// size coding
	// ----------------------------------------------------------------
	localparam logic [2:0]        SZ_128  = 3'h0;
	localparam logic [2:0]        SZ_256  = 3'h1;
	localparam logic [2:0]        SZ_512  = 3'h2;
	localparam logic [2:0]        SZ_1024 = 3'h3;
	localparam logic [2:0]        SZ_2048 = 3'h4;
	localparam logic [2:0]        SZ_4096 = 3'h5;
	localparam logic [SIZE_W-1:0] B_128   = 13'h0080;

	// error message kinds sent upstream
	typedef enum logic [1:0] {
		MSG_CORR     = 2'h0,
		MSG_NONFATAL = 2'h1,
		MSG_FATAL    = 2'h3
	} pdc_msg_t;

	// size code to bytes; reserved codes fall back to the smallest size
	function automatic logic [SIZE_W-1:0] pdc_size_bytes(input logic [2:0] code);
		logic [SIZE_W-1:0] res;
		res = B_128;
		if (code <= SZ_4096)
			res = B_128 << code;
		return res;
	endfunction : pdc_size_bytes

endpackage : pdc_pkg
`default_nettype wire

// file: rtl/pdc_err_msg.sv
// error message emitter: queues one request per kind, sends most severe first
`default_nettype none
module pdc_err_msg
	import pdc_pkg::*;
(
	input  wire logic     clock_i,          // core clock
	input  wire logic     reset_i,          // synchronous reset, active high
	input  wire logic     req_fatal_i,      // fatal report request pulse
	input  wire logic     req_nonfatal_i,   // nonfatal report request pulse
	input  wire logic     req_corr_i,       // correctable report request pulse
	input  wire logic     msg_ready_i,      // upstream takes message
	output logic          msg_valid_o,      // message offered
	output var pdc_msg_t  msg_type_o        // message kind
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} pdc_em_state_t;

	pdc_em_state_t state;
	pdc_em_state_t next_state;
	logic [2:0]    pend;
	logic [2:0]    req;
	logic [2:0]    done;
	logic          take;

	assign req         = {req_fatal_i, req_nonfatal_i, req_corr_i};
	assign msg_valid_o = (state == ST_SEND);
	assign take        = msg_valid_o & msg_ready_i;

	// ----------------------------------------------------------------
	// pending requests, a new request beats the clear
	// ----------------------------------------------------------------
	always_comb
	begin
		done = 3'h0;
		if (take)
		begin
			case (msg_type_o)
				MSG_FATAL:    done = 3'h4;
				MSG_NONFATAL: done = 3'h2;
				default:      done = 3'h1;
			endcase
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			pend <= 3'h0;
		else
			pend <= (pend & ~done) | req;
	end

	always_comb
	begin
		case (state)
			ST_IDLE: next_state = (pend != 3'h0) ? ST_SEND : ST_IDLE;
			ST_SEND: next_state = take ? ST_IDLE : ST_SEND;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// kind is latched on entry to send and held until taken
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			msg_type_o <= MSG_CORR;
		else if (state == ST_IDLE)
		begin
			if (pend[2])
				msg_type_o <= MSG_FATAL;
			else if (pend[1])
				msg_type_o <= MSG_NONFATAL;
			else
				msg_type_o <= MSG_CORR;
		end
	end

endmodule : pdc_err_msg
`default_nettype wire

// file: rtl/pdc_ctrl.sv
// device control and status registers with error reporting and fetch sizing
`default_nettype none
module pdc_ctrl
	import pdc_pkg::*;
#(
	parameter int CLS_W = CLS_W_DEF
)
(
	input  wire logic              clock_i,           // core clock
	input  wire logic              reset_i,           // synchronous reset, active high
	input  wire logic [11:0]       cfg_addr_i,        // config byte address
	input  wire logic              cfg_wr_i,          // config write strobe
	input  wire logic              cfg_rd_i,          // config read strobe
	input  wire logic [1:0]        cfg_be_i,          // byte enables
	input  wire logic [15:0]       cfg_wdata_i,       // write data
	output logic [15:0]            cfg_rdata_o,       // read data
	output logic                   cfg_ack_o,         // access done
	input  wire logic [CLS_W-1:0]  cache_line_size_i, // cache line size, dwords
	input  wire logic              ur_event_i,        // unsupported request pulse
	input  wire logic              fatal_event_i,     // fatal error pulse
	input  wire logic              nonfatal_event_i,  // nonfatal error pulse
	input  wire logic              corr_event_i,      // correctable error pulse
	input  wire logic              pending_i,         // non-posted pending, async
	input  wire logic              aux_power_i,       // aux power present, async
	input  wire logic              msg_ready_i,       // upstream takes message
	output logic                   msg_valid_o,       // error message offered
	output var pdc_msg_t           msg_type_o,        // error message kind
	output logic [2:0]             max_read_req_size_o, // read request code
	output logic [2:0]             max_payload_limit_o, // payload code
	output logic [SIZE_W-1:0]      fetch_bytes_o,     // bytes per read fetch
	output logic [SIZE_W-1:0]      payload_bytes_o,   // bytes per payload
	output logic [3:0]             report_en_o        // ur, fatal, nonfatal, corr
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (CLS_W < 1 || CLS_W > CLS_W_MAX)
	begin : g_bad_cls
		$error("pdc_ctrl: CLS_W out of range");
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [15:0]       ctrl;
	logic [15:0]       next_ctrl;
	logic [3:0]        stat_err;
	logic [15:0]       stat_view;
	logic [15:0]       lane_mask;
	logic              hit_ctrl;
	logic              hit_stat;
	logic              wr_ctrl;
	logic              wr_stat;
	logic [3:0]        err_set;
	logic [3:0]        err_clr;
	logic [1:0]        pend_sync;
	logic [1:0]        aux_sync;
	logic              rep_fatal;
	logic              rep_nonfatal;
	logic              rep_corr;
	logic [SIZE_W-1:0] rrs_bytes;
	logic [SIZE_W-1:0] cls_bytes;
	logic [SIZE_W-1:0] next_fetch;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	assign hit_ctrl  = (cfg_addr_i == PCIE_DEVICE_CONTROL_OFS);
	assign hit_stat  = (cfg_addr_i == PCIE_DEVICE_STATUS_OFS);
	assign wr_ctrl   = cfg_wr_i & hit_ctrl;
	assign wr_stat   = cfg_wr_i & hit_stat;
	assign lane_mask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

	// ----------------------------------------------------------------
	// device control register
	// ----------------------------------------------------------------
	// only writable fields take data; reserved and fixed bits stay zero
	always_comb
	begin
		next_ctrl = ctrl;
		if (wr_ctrl)
			next_ctrl = (ctrl & ~(CTRL_WR_MASK & lane_mask))
				| (cfg_wdata_i & CTRL_WR_MASK & lane_mask); // R01 R02 R04 R05 R06 R07 R08 R09
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			ctrl <= PCIE_DEVICE_CONTROL_RST; // R15
		else
			ctrl <= next_ctrl;
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			pend_sync <= 2'h0;
			aux_sync  <= 2'h0;
		end
		else
		begin
			pend_sync <= {pend_sync[0], pending_i};
			aux_sync  <= {aux_sync[0], aux_power_i};
		end
	end

	// ----------------------------------------------------------------
	// device status error flags, write one to clear, set wins
	// ----------------------------------------------------------------
	assign err_set = {ur_event_i, fatal_event_i, nonfatal_event_i, corr_event_i};
	assign err_clr = (wr_stat && cfg_be_i[0]) ? (cfg_wdata_i[3:0] & STAT_W1C_MASK[3:0]) : 4'h0;

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			stat_err <= PCIE_DEVICE_STATUS_RST[3:0];
		else
			stat_err <= (stat_err & ~err_clr) | err_set; // R14
	end

	always_comb
	begin
		stat_view              = PCIE_DEVICE_STATUS_RST;
		stat_view[3:0]         = stat_err;
		stat_view[ST_AUX_BIT]  = aux_sync[1];
		stat_view[ST_PEND_BIT] = pend_sync[1];
	end

	// ----------------------------------------------------------------
	// configuration read path
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			cfg_ack_o   <= 1'b0;
			cfg_rdata_o <= RD_UNMAPPED;
		end
		else
		begin
			cfg_ack_o <= cfg_wr_i | cfg_rd_i;
			if (cfg_rd_i && hit_ctrl)
				cfg_rdata_o <= ctrl & lane_mask; // R01 R05 R06 R07 R08 R09
			else if (cfg_rd_i && hit_stat)
				cfg_rdata_o <= stat_view & lane_mask;
			else
				cfg_rdata_o <= RD_UNMAPPED;
		end
	end

	// ----------------------------------------------------------------
	// error reporting
	// ----------------------------------------------------------------
	assign rep_fatal    = fatal_event_i & ctrl[FATAL_REP_BIT]; // R11
	assign rep_nonfatal = (ur_event_i & ctrl[UR_REP_BIT]) // R10
		| (nonfatal_event_i & ctrl[NF_REP_BIT]); // R12
	assign rep_corr     = corr_event_i & ctrl[CORR_REP_BIT]; // R13

	pdc_err_msg u_err_msg (
		.clock_i        (clock_i),
		.reset_i        (reset_i),
		.req_fatal_i    (rep_fatal),
		.req_nonfatal_i (rep_nonfatal),
		.req_corr_i     (rep_corr),
		.msg_ready_i    (msg_ready_i),
		.msg_valid_o    (msg_valid_o),
		.msg_type_o     (msg_type_o)
	);

	// ----------------------------------------------------------------
	// size limits and fetch sizing
	// ----------------------------------------------------------------
	assign rrs_bytes  = pdc_size_bytes(ctrl[RRS_LSB +: 3]); // R02
	assign cls_bytes  = SIZE_W'({cache_line_size_i, 2'b00});

	// fetch one cache line when it is set and smaller than the request cap
	always_comb
	begin
		next_fetch = rrs_bytes;
		if (cls_bytes != '0 && cls_bytes < rrs_bytes)
			next_fetch = cls_bytes; // R03
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			max_read_req_size_o <= PCIE_DEVICE_CONTROL_RST[RRS_LSB +: 3];
			max_payload_limit_o <= PCIE_DEVICE_CONTROL_RST[MPL_LSB +: 3];
			fetch_bytes_o       <= pdc_size_bytes(PCIE_DEVICE_CONTROL_RST[RRS_LSB +: 3]);
			payload_bytes_o     <= pdc_size_bytes(PCIE_DEVICE_CONTROL_RST[MPL_LSB +: 3]);
			report_en_o         <= PCIE_DEVICE_CONTROL_RST[3:0];
		end
		else
		begin
			max_read_req_size_o <= ctrl[RRS_LSB +: 3]; // R02
			max_payload_limit_o <= ctrl[MPL_LSB +: 3]; // R04
			fetch_bytes_o       <= next_fetch;
			payload_bytes_o     <= pdc_size_bytes(ctrl[MPL_LSB +: 3]); // R04
			report_en_o         <= ctrl[3:0];
		end
	end

endmodule : pdc_ctrl
`default_nettype wire

// file: tb/pdc_ctrl_props.sv
// assertion checker for the device control register block
`default_nettype none
module pdc_ctrl_props
	import pdc_pkg::*;
(
	input wire logic        clock_i,             // clock
	input wire logic        reset_i,             // reset
	input wire logic [11:0] cfg_addr_i,          // address
	input wire logic        cfg_wr_i,            // write
	input wire logic        cfg_rd_i,            // read
	input wire logic [1:0]  cfg_be_i,            // byte enables
	input wire logic [15:0] cfg_wdata_i,         // write data
	input wire logic [15:0] cfg_rdata_o,         // read data
	input wire logic        cfg_ack_o,           // ack
	input wire logic        ur_event_i,          // ur event
	input wire logic        fatal_event_i,       // fatal event
	input wire logic        msg_ready_i,         // taken
	input wire logic        msg_valid_o,         // offered
	input wire pdc_msg_t    msg_type_o,          // kind
	input wire logic [2:0]  max_read_req_size_o, // read size
	input wire logic [2:0]  max_payload_limit_o, // payload
	input wire logic [3:0]  report_en_o          // enables
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	logic ctl;
	logic wr_ctl;
	assign ctl = cfg_addr_i == PCIE_DEVICE_CONTROL_OFS;
	assign wr_ctl = cfg_wr_i && ctl;

	property p_rdbk;
		cfg_rd_i && ctl && cfg_be_i == 2'h3 |=> cfg_ack_o && cfg_rdata_o ==
			{1'b0, max_read_req_size_o, 4'h0, max_payload_limit_o, 1'b0, report_en_o};
	endproperty
	a_rdbk: assert property (p_rdbk) else $error("bad control read");
	property p_rrs;
		wr_ctl && cfg_be_i[1] |=> ##1 max_read_req_size_o == $past(cfg_wdata_i[14:12], 2);
	endproperty
	a_rrs: assert property (p_rrs) else $error("read size not written");
	property p_mpl;
		wr_ctl && cfg_be_i[0] |=> ##1 max_payload_limit_o == $past(cfg_wdata_i[7:5], 2);
	endproperty
	a_mpl: assert property (p_mpl) else $error("payload not written");
	property p_ren;
		wr_ctl && cfg_be_i[0] |=> ##1 report_en_o == $past(cfg_wdata_i[3:0], 2);
	endproperty
	a_ren: assert property (p_ren) else $error("enables not written");
	property p_keep;
		!wr_ctl |=> ##1 $stable(max_read_req_size_o) && $stable(max_payload_limit_o)
			&& $stable(report_en_o);
	endproperty
	a_keep: assert property (p_keep) else $error("fields moved");
	property p_fat;
		fatal_event_i ##1 report_en_o[2] |-> ##[1:19] msg_valid_o && msg_type_o == MSG_FATAL;
	endproperty
	a_fat: assert property (p_fat) else $error("fatal not sent");
	property p_ur;
		ur_event_i ##1 report_en_o[3] |-> ##[1:19] msg_valid_o && msg_type_o == MSG_NONFATAL;
	endproperty
	a_ur: assert property (p_ur) else $error("ur not sent");
	property p_hold;
		msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_type_o);
	endproperty
	a_hold: assert property (p_hold) else $error("message dropped");
endmodule : pdc_ctrl_props

bind pdc_ctrl pdc_ctrl_props i_props (.clock_i(clock_i), .reset_i(reset_i),
	.cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_be_i(cfg_be_i),
	.cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
	.ur_event_i(ur_event_i), .fatal_event_i(fatal_event_i), .msg_ready_i(msg_ready_i),
	.msg_valid_o(msg_valid_o), .msg_type_o(msg_type_o), .report_en_o(report_en_o),
	.max_read_req_size_o(max_read_req_size_o), .max_payload_limit_o(max_payload_limit_o));
`default_nettype wire

// file: tb/pdc_msg_sink.sv
// upstream message taker, prompt or stalled
`default_nettype none
module pdc_msg_sink
(
	input  wire logic clock_i,     // clock
	input  wire logic msg_valid_i, // offered
	input  wire logic stall_i,     // hold off
	output var logic  msg_ready_o  // taken
);
	timeunit 1ns;
	timeprecision 1ps;
	initial msg_ready_o = 1'b0;
	always @(negedge clock_i)
		msg_ready_o <= msg_valid_i && !stall_i;
endmodule : pdc_msg_sink
`default_nettype wire

// file: tb/pdc_ctrl_test.sv
// testbench for the device control register block
`default_nettype none
module pdc_ctrl_test
	import pdc_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] CTL = PCIE_DEVICE_CONTROL_OFS;
	logic        clock_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [11:0] cfg_addr_i = 12'h000;
	logic        cfg_wr_i = 1'b0;
	logic        cfg_rd_i = 1'b0;
	logic [1:0]  cfg_be_i = 2'h0;
	logic [15:0] cfg_wdata_i = 16'h0000;
	logic [7:0]  cls = 8'h00;
	logic [3:0]  ev = 4'h0;
	logic        stall = 1'b0;
	logic [15:0] cfg_rdata_o;
	logic [15:0] rd;
	logic        cfg_ack_o;
	logic        msg_valid_o;
	logic        msg_ready_i;
	pdc_msg_t    msg_type_o;
	logic [2:0]  rrs;
	logic [2:0]  mpl;
	logic [12:0] fetch;
	logic [12:0] pay;
	logic [3:0]  ren;
	pdc_msg_t    got[$];
	int          num_errors = 0;
	int          checks = 0;

	always #5 clock_i = ~clock_i;
	// count a message once both sides stand settled before the taking edge
	always @(negedge clock_i)
	begin
		#1;
		if (msg_valid_o && msg_ready_i)
			got.push_back(msg_type_o);
	end

	pdc_ctrl i_dut (.clock_i(clock_i), .reset_i(reset_i), .cfg_addr_i(cfg_addr_i),
		.cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_be_i(cfg_be_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
		.cache_line_size_i(cls), .ur_event_i(ev[3]), .fatal_event_i(ev[2]),
		.nonfatal_event_i(ev[1]), .corr_event_i(ev[0]), .pending_i(1'b0),
		.aux_power_i(1'b0), .msg_ready_i(msg_ready_i), .msg_valid_o(msg_valid_o),
		.msg_type_o(msg_type_o), .max_read_req_size_o(rrs), .max_payload_limit_o(mpl),
		.fetch_bytes_o(fetch), .payload_bytes_o(pay), .report_en_o(ren));
	pdc_msg_sink i_sink (.clock_i(clock_i), .msg_valid_i(msg_valid_o), .stall_i(stall),
		.msg_ready_o(msg_ready_i));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic acc(input logic wr, input logic [11:0] a, input logic [1:0] be,
		input logic [15:0] d);
		@(negedge clock_i);
		cfg_wr_i = wr;
		cfg_rd_i = !wr;
		cfg_addr_i = a;
		cfg_be_i = be;
		cfg_wdata_i = d;
		@(negedge clock_i);
		cfg_wr_i = 1'b0;
		cfg_rd_i = 1'b0;
		rd = cfg_rdata_o;
		check({15'h0000, cfg_ack_o}, 16'h0001);
	endtask : acc

	task automatic rdchk(input logic [11:0] a, input logic [15:0] exp);
		acc(1'b0, a, 2'h3, 16'h0000);
		check(rd, exp);
	endtask : rdchk

	task automatic fire(input logic [3:0] m);
		@(negedge clock_i);
		ev = m;
		@(negedge clock_i);
		ev = 4'h0;
	endtask : fire

	task automatic wait_msgs(input int n);
		for (int i = 0; i < 30 && got.size() < n; i++)
			@(negedge clock_i);
		check(16'(got.size()), 16'(n));
		if (got.size() < n)
			report_and_stop();
	endtask : wait_msgs

	task automatic t_reset();
		rdchk(CTL, 16'h2000);
		check({10'h000, rrs, mpl}, {10'h000, SZ_512, SZ_128});
		check({3'h0, fetch}, 16'h0200);
		check({3'h0, pay}, 16'h0080);
		check({12'h000, ren}, 16'h0000);
		rdchk(12'h09C, 16'h0000);
		$display("reset test done");
	endtask : t_reset

	task automatic t_fields();
		logic [2:0] c;
		for (int i = 0; i < 8; i++)
		begin
			c = 3'(i);
			acc(1'b1, CTL, 2'h3, {1'b1, c, 4'hF, c, 1'b1, c[0], c});
			rdchk(CTL, {1'b0, c, 4'h0, c, 1'b0, c[0], c});
			check({10'h000, rrs, mpl}, {10'h000, c, c});
			check({3'h0, pay}, (i < 6) ? 16'h0080 << i : 16'h0080);
			check({12'h000, ren}, {12'h000, c[0], c});
		end
		acc(1'b1, CTL, 2'h1, 16'h0000);
		rdchk(CTL, 16'h7000);
		$display("field test done");
	endtask : t_fields

	task automatic t_fetch();
		acc(1'b1, CTL, 2'h3, 16'h2000);
		cls = 8'h10;
		repeat (2) @(negedge clock_i);
		check({3'h0, fetch}, 16'h0040);
		cls = 8'hFF;
		repeat (2) @(negedge clock_i);
		check({3'h0, fetch}, 16'h0200);
		acc(1'b1, CTL, 2'h3, 16'h5000);
		@(negedge clock_i);
		check({3'h0, fetch}, 16'h03FC);
		$display("fetch test done");
	endtask : t_fetch

	task automatic t_msgs();
		pdc_msg_t want[4] = '{MSG_CORR, MSG_NONFATAL, MSG_FATAL, MSG_NONFATAL};
		acc(1'b1, CTL, 2'h3, 16'h2000);
		fire(4'hF);
		repeat (10) @(negedge clock_i);
		check(16'(got.size()), 16'h0000);
		rdchk(PCIE_DEVICE_STATUS_OFS, 16'h000F);
		for (int k = 0; k < 4; k++)
		begin
			acc(1'b1, CTL, 2'h3, 16'h2000 | (16'h0001 << k));
			fire(4'hF);
			wait_msgs(1);
			repeat (10) @(negedge clock_i);
			check(16'(got.size()), 16'h0001);
			check({14'h0000, got.pop_front()}, {14'h0000, want[k]});
		end
		acc(1'b1, CTL, 2'h3, 16'h200F);
		stall = 1'b1;
		fire(4'hF);
		repeat (4) @(negedge clock_i);
		stall = 1'b0;
		wait_msgs(3);
		check({14'h0000, got[0]}, {14'h0000, MSG_FATAL});
		check({14'h0000, got[1]}, {14'h0000, MSG_NONFATAL});
		check({14'h0000, got[2]}, {14'h0000, MSG_CORR});
		$display("message test done");
	endtask : t_msgs

	initial
	begin
		repeat (2) @(negedge clock_i);
		reset_i = 1'b0;
		t_reset();
		t_fields();
		t_fetch();
		t_msgs();
		report_and_stop();
	end
endmodule : pdc_ctrl_test
`default_nettype wire
